// file: logic/sifd_core.v
// Serial peripheral controller: enables, event flags, data path and shifter
`timescale 1ns/100ps
`include "sifd_consts.vh"

module sifd_core (
  input wire clock,
  input wire rst,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire irq_ack,
  output reg irq,
  input wire sck_i,
  output reg sck_o,
  output reg sck_oe,
  input wire mosi_i,
  output reg mosi_o,
  output reg mosi_oe,
  input wire miso_i,
  output reg miso_o,
  output reg miso_oe,
  input wire ss_n_i
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function out_bit;
    input [7:0] sr;
    input lsb_first;
    begin
      out_bit = lsb_first ? sr[0] : sr[7];
    end
  endfunction

  function [7:0] shift_in;
    input [7:0] sr;
    input lsb_first;
    input b;
    begin
      shift_in = lsb_first ? {b, sr[7:1]} : {sr[6:0], b};
    end
  endfunction

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  reg [7:0] ctrl_a_ff;
  reg [7:0] ctrl_b_ff;
  reg [7:0] enables_ff;
  wire run = ctrl_a_ff[`SIFD_CA_RUN];
  wire master = ctrl_a_ff[`SIFD_CA_MASTER];
  wire dord = ctrl_a_ff[`SIFD_CA_DORD];
  wire buffered_mode_en = ctrl_b_ff[`SIFD_CB_BUFFERED_MODE_EN];
  wire select_line_disable = ctrl_b_ff[`SIFD_CB_SSD];
  wire cpha = ctrl_b_ff[0];
  wire cpol = ctrl_b_ff[1];
  wire wr_ca = reg_wr & (reg_addr == `SIFD_OFF_CTRL_A);
  wire wr_cb = reg_wr & (reg_addr == `SIFD_OFF_CTRL_B);
  wire wr_en = reg_wr & (reg_addr == `SIFD_OFF_ENABLES);
  wire wr_flags = reg_wr & (reg_addr == `SIFD_OFF_FLAGS);
  wire rd_flags = reg_rd & (reg_addr == `SIFD_OFF_FLAGS);
  wire wr_data = reg_wr & (reg_addr == `SIFD_OFF_DATA);
  wire rd_data = reg_rd & (reg_addr == `SIFD_OFF_DATA);
  wire acc_data = wr_data | rd_data;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Order: ss_n, sck, mosi, miso
  reg [3:0] pin_s1_ff;
  reg [3:0] pin_s2_ff;
  reg [3:0] pin_s3_ff;
  reg [3:0] pin_f_ff;
  reg [3:0] pin_fd_ff;
  wire [3:0] agree = ~(pin_s2_ff ^ pin_s3_ff);

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      // Idle levels: select high, clock low, data high; no false edge at release
      pin_s1_ff <= 4'hB;
      pin_s2_ff <= 4'hB;
      pin_s3_ff <= 4'hB;
      pin_f_ff <= 4'hB;
      pin_fd_ff <= 4'hB;
    end else begin
      pin_s1_ff <= {ss_n_i, sck_i, mosi_i, miso_i};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_f_ff <= (pin_f_ff & ~agree) | (pin_s3_ff & agree);
      pin_fd_ff <= pin_f_ff;
    end
  end

  wire ss_low = ~pin_f_ff[3];
  wire sck_edge = pin_f_ff[2] ^ pin_fd_ff[2];
  // Select pulled low under a master forces slave role
  wire mode_fault = run & master & ~select_line_disable & ss_low;
  wire slave_act = run & ~master & ss_low;

  // ----------------------------------------
  // Shifter and master clock divider
  // ----------------------------------------
  reg [7:0] sr_ff;
  reg [2:0] bitcnt_ff;
  reg busy_ff;
  reg sr_full_ff;
  reg sck_ff;
  reg out_ff;
  reg [6:0] hcnt_ff;
  reg [3:0] ecnt_ff;
  reg [7:0] tx_buf_ff;
  reg tx_full_ff;
  reg [6:0] half;

  always @* begin
    case (ctrl_a_ff[2:1])
      2'h0: half = `SIFD_HALF_DIV4;
      2'h1: half = `SIFD_HALF_DIV16;
      2'h2: half = `SIFD_HALF_DIV64;
      2'h3: half = `SIFD_HALF_DIV128;
      default: half = `SIFD_HALF_DIV4;
    endcase
    if (ctrl_a_ff[`SIFD_CA_CLK2X])
      half = {1'b0, half[6:1]};
  end

  wire tick = busy_ff & (hcnt_ff == 7'h00);
  wire lead_m = tick & ~ecnt_ff[0];
  wire trail_m = tick & ecnt_ff[0];
  wire lead_s = slave_act & sck_edge & (pin_f_ff[2] == ~cpol);
  wire trail_s = slave_act & sck_edge & (pin_f_ff[2] == cpol);
  wire lead = master ? lead_m : lead_s;
  wire trail = master ? trail_m : trail_s;
  wire samp = cpha ? trail : lead;
  wire setp = cpha ? lead : trail;
  wire in_bit = master ? pin_f_ff[0] : pin_f_ff[1];
  wire [7:0] sr_in = shift_in(sr_ff, dord, in_bit);
  wire byte_done = samp & (bitcnt_ff == 3'h7);
  wire xfer_end = master ? (tick & (ecnt_ff == 4'hF)) : byte_done;
  wire nb_busy = master ? busy_ff : (bitcnt_ff != 3'h0);
  wire bf_busy = master ? busy_ff : (sr_full_ff | (bitcnt_ff != 3'h0));
  // Buffered mode moves the waiting byte on; plain mode loads straight
  wire load = run & ~mode_fault & (buffered_mode_en ? (tx_full_ff & ~bf_busy)
                                                    : (wr_data & ~nb_busy));
  wire [7:0] load_val = buffered_mode_en ? tx_buf_ff : reg_wdata;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sr_ff <= `SIFD_RST_REG;
      bitcnt_ff <= 3'h0;
      busy_ff <= 1'b0;
      sr_full_ff <= 1'b0;
      sck_ff <= 1'b0;
      out_ff <= 1'b0;
      hcnt_ff <= 7'h00;
      ecnt_ff <= 4'h0;
    end else if (mode_fault | ~run) begin
      busy_ff <= 1'b0;
      bitcnt_ff <= 3'h0;
      sr_full_ff <= 1'b0;
      sck_ff <= cpol;
    end else if (load) begin
      sr_ff <= load_val;
      sr_full_ff <= 1'b1;
      busy_ff <= master;
      bitcnt_ff <= 3'h0;
      hcnt_ff <= half - 7'h01;
      ecnt_ff <= 4'h0;
      if (~cpha)
        out_ff <= out_bit(load_val, dord);
    end else begin
      if (samp) begin
        sr_ff <= sr_in;
        bitcnt_ff <= bitcnt_ff + 3'h1;
      end
      if (byte_done)
        sr_full_ff <= 1'b0;
      if (setp)
        out_ff <= out_bit(sr_ff, dord);
      if (busy_ff) begin
        if (tick) begin
          sck_ff <= ~sck_ff;
          ecnt_ff <= ecnt_ff + 4'h1;
          hcnt_ff <= half - 7'h01;
          if (ecnt_ff == 4'hF)
            busy_ff <= 1'b0;
        end else begin
          hcnt_ff <= hcnt_ff - 7'h01;
        end
      end else begin
        sck_ff <= cpol;
      end
      // Select released mid-byte: drop the partial byte
      if (~master & ~slave_act)
        bitcnt_ff <= 3'h0;
    end
  end

  // ----------------------------------------
  // Transmit buffer
  // ----------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_buf_ff <= `SIFD_RST_REG;
      tx_full_ff <= 1'b0;
    end else begin
      if (wr_data & buffered_mode_en)
        tx_buf_ff <= reg_wdata;
      // Write wins over the hand-off taking the previous byte
      tx_full_ff <= (wr_data & buffered_mode_en) |
                    (tx_full_ff & ~(load & buffered_mode_en));
    end
  end

  // ----------------------------------------
  // Receive buffer: entry 2 is the head
  // ----------------------------------------
  reg [7:0] rx1_ff;
  reg [7:0] rx2_ff;
  reg [1:0] rx_cnt_ff;
  wire pop = rd_data & buffered_mode_en & (rx_cnt_ff != 2'h0);
  wire clr_rx = wr_flags & buffered_mode_en & reg_wdata[`SIFD_F_RXC];
  wire [1:0] cap = clr_rx ? 2'h0 : (rx_cnt_ff - {1'b0, pop});
  wire full_hit = byte_done & buffered_mode_en & (cap == 2'h2);

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rx1_ff <= `SIFD_RST_REG;
      rx2_ff <= `SIFD_RST_REG;
      rx_cnt_ff <= 2'h0;
    end else begin
      if (pop)
        rx2_ff <= rx1_ff;
      if (byte_done & ~buffered_mode_en)
        rx2_ff <= sr_in;
      if (byte_done & buffered_mode_en & (cap == 2'h0))
        rx2_ff <= sr_in;
      if (byte_done & buffered_mode_en & (cap == 2'h1))
        rx1_ff <= sr_in;
      // Third byte is dropped, both entries kept
      if (byte_done & buffered_mode_en & (cap != 2'h2))
        rx_cnt_ff <= cap + 2'h1;
      else
        rx_cnt_ff <= cap;
    end
  end

  // ----------------------------------------
  // Event flags
  // ----------------------------------------
  reg if_ff;
  reg if_arm_ff;
  reg write_collision_flag_ff;
  reg wc_arm_ff;
  reg txc_ff;
  reg select_trigger_flag_ff;
  reg ovf_ff;
  reg ovf_pend_ff;
  wire nb = ~buffered_mode_en;
  wire if_set = nb & (byte_done | mode_fault);
  wire if_clr = irq_ack | (acc_data & if_arm_ff);
  wire wc_set = nb & run & wr_data & nb_busy;
  wire wc_clr = acc_data & wc_arm_ff;
  wire txc_set = buffered_mode_en & xfer_end & ~tx_full_ff;
  wire txc_clr = wr_flags & buffered_mode_en & reg_wdata[`SIFD_F_TXC];
  wire ss_set = buffered_mode_en & mode_fault;
  wire ss_clr = wr_flags & buffered_mode_en & reg_wdata[`SIFD_F_SS];
  wire ovf_set = (full_hit & tx_full_ff) |
                 (buffered_mode_en & load & ovf_pend_ff);
  wire pend_set = full_hit & ~tx_full_ff;

  // Every flag but the empty flag: hardware set beats any clear in the same cycle
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      if_ff <= 1'b0;
      if_arm_ff <= 1'b0;
      write_collision_flag_ff <= 1'b0;
      wc_arm_ff <= 1'b0;
      txc_ff <= 1'b0;
      select_trigger_flag_ff <= 1'b0;
      ovf_ff <= 1'b0;
      ovf_pend_ff <= 1'b0;
    end else begin
      if_ff <= if_set | (if_ff & ~if_clr);
      if_arm_ff <= (rd_flags & if_ff) | (if_arm_ff & ~acc_data);
      write_collision_flag_ff <= wc_set | (write_collision_flag_ff & ~wc_clr);
      wc_arm_ff <= (rd_flags & write_collision_flag_ff) | (wc_arm_ff & ~acc_data);
      txc_ff <= txc_set | (txc_ff & ~txc_clr);
      select_trigger_flag_ff <= ss_set | (select_trigger_flag_ff & ~ss_clr);
      ovf_ff <= ovf_set | (ovf_ff & ~rd_data);
      ovf_pend_ff <= pend_set | (ovf_pend_ff & ~(load | rd_data));
    end
  end

  wire rx_done_flag = rx_cnt_ff != 2'h0;
  wire tx_buf_empty_flag = buffered_mode_en & ~tx_full_ff;
  wire [7:0] flags_view = buffered_mode_en ?
    {rx_done_flag, txc_ff, tx_buf_empty_flag, select_trigger_flag_ff, 3'h0, ovf_ff} :
    {if_ff, write_collision_flag_ff, 6'h00};

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_a_ff <= `SIFD_RST_REG;
      ctrl_b_ff <= `SIFD_RST_REG;
      enables_ff <= `SIFD_RST_REG;
    end else begin
      if (wr_ca)
        ctrl_a_ff <= reg_wdata & `SIFD_CA_MASK;
      // Fault wins: software must rewrite the master bit
      if (mode_fault)
        ctrl_a_ff[`SIFD_CA_MASTER] <= 1'b0;
      if (wr_cb)
        ctrl_b_ff <= reg_wdata & `SIFD_CB_MASK;
      if (wr_en)
        enables_ff <= reg_wdata & `SIFD_EN_MASK;
    end
  end

  reg [7:0] rd_val;
  always @* begin
    case (reg_addr)
      `SIFD_OFF_CTRL_A: rd_val = ctrl_a_ff;
      `SIFD_OFF_CTRL_B: rd_val = ctrl_b_ff;
      `SIFD_OFF_ENABLES: rd_val = buffered_mode_en ? enables_ff
                                                   : (enables_ff & 8'h01);
      `SIFD_OFF_FLAGS: rd_val = flags_view;
      `SIFD_OFF_DATA: rd_val = rx2_ff;
      default: rd_val = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Enabled empty flag keeps the request up until data is written
  wire [3:0] buf_req = {rx_done_flag, txc_ff, tx_buf_empty_flag, select_trigger_flag_ff} &
                       enables_ff[7:4];
  wire irq_nxt = buffered_mode_en ? (|buf_req)
                                  : (if_ff & enables_ff[`SIFD_IE_LEGACY]);

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      irq <= 1'b0;
      sck_o <= 1'b0;
      sck_oe <= 1'b0;
      mosi_o <= 1'b0;
      mosi_oe <= 1'b0;
      miso_o <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_val : 8'h00;
      irq <= irq_nxt;
      sck_o <= sck_ff;
      sck_oe <= run & master;
      mosi_o <= out_ff;
      mosi_oe <= run & master;
      miso_o <= out_ff;
      miso_oe <= slave_act;
    end
  end

endmodule // sifd_core

// file: logic/sifd_consts.vh
// Register map, field positions, reset values and divider counts
`ifndef SIFD_CONSTS_VH
`define SIFD_CONSTS_VH
`define SIFD_OFF_CTRL_A 3'h0
`define SIFD_OFF_CTRL_B 3'h1
`define SIFD_OFF_ENABLES 3'h2
`define SIFD_OFF_FLAGS 3'h3
`define SIFD_OFF_DATA 3'h4
`define SIFD_CA_RUN 0
`define SIFD_CA_CLK2X 4
`define SIFD_CA_MASTER 5
`define SIFD_CA_DORD 6
`define SIFD_CB_SSD 2
`define SIFD_CB_BUFFERED_MODE_EN 7
`define SIFD_F_RXC 7
`define SIFD_F_TXC 6
`define SIFD_F_DRE 5
`define SIFD_F_SS 4
`define SIFD_F_OVF 0
`define SIFD_IE_LEGACY 0
`define SIFD_CA_MASK 8'h77
`define SIFD_CB_MASK 8'hC7
`define SIFD_EN_MASK 8'hF1
`define SIFD_RST_REG 8'h00
`define SIFD_HALF_DIV4 7'h02
`define SIFD_HALF_DIV16 7'h08
`define SIFD_HALF_DIV64 7'h20
`define SIFD_HALF_DIV128 7'h40
`endif

// file: verif/sifd_core_chk.sv
// Concurrent checks on the serial controller's register and link ports
`timescale 1ns/100ps
module sifd_core_chk (
  input wire clock,
  input wire rst,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire irq,
  input wire sck_o,
  input wire sck_oe,
  input wire ss_n_i
);
  // ----------------------------------------
  // Shadow state seen through the bus and the link clock output
  // ----------------------------------------
  reg [7:0] ca_ff;
  reg [7:0] cb_ff;
  reg [7:0] en_ff;
  reg [3:0] idle_ff;
  reg sck_q_ff;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ca_ff <= 8'h00;
      cb_ff <= 8'h00;
      en_ff <= 8'h00;
      idle_ff <= 4'h0;
      sck_q_ff <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 3'h0) ca_ff <= reg_wdata;
      if (reg_wr && reg_addr == 3'h1) cb_ff <= reg_wdata;
      if (reg_wr && reg_addr == 3'h2) en_ff <= reg_wdata;
      sck_q_ff <= sck_o;
      // Saturating count of quiet clock cycles marks an idle link
      if (sck_o != sck_q_ff) idle_ff <= 4'h0;
      else if (idle_ff != 4'hF) idle_ff <= idle_ff + 4'h1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking chk_cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_en_zero;
    reg_rd && reg_addr == 3'h2 && !cb_ff[7] |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_en_zero: assert property (p_en_zero)
    else $error("buffered enables visible in plain mode");
  property p_nb_zero;
    reg_rd && reg_addr == 3'h3 && !cb_ff[7] |=> reg_rdata[5:0] == 6'h00;
  endproperty
  a_nb_zero: assert property (p_nb_zero)
    else $error("buffered flags visible in plain mode");
  property p_irq_legacy;
    reg_rd && reg_addr == 3'h3 ##1 reg_rdata[7] && en_ff[0] && !cb_ff[7] |-> irq;
  endproperty
  a_irq_legacy: assert property (p_irq_legacy)
    else $error("enabled transfer flag without interrupt");
  property p_irq_quiet;
    en_ff == 8'h00 && $past(en_ff) == 8'h00 |-> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt with every source disabled");
  property p_ovf_clear;
    reg_rd && reg_addr == 3'h4 && cb_ff[7] ##2 reg_rd && reg_addr == 3'h3 |=> !reg_rdata[0];
  endproperty
  a_ovf_clear: assert property (p_ovf_clear)
    else $error("overrun still set after data read");
  property p_mode_fault;
    (ca_ff[5] && ca_ff[0] && !cb_ff[2] && !ss_n_i) [*4] |-> ##[0:4] !sck_oe;
  endproperty
  a_mode_fault: assert property (p_mode_fault)
    else $error("master kept driving after select pulled low");
  property p_start;
    reg_wr && reg_addr == 3'h4 && ca_ff == 8'h35 && cb_ff == 8'h00 && ss_n_i && idle_ff == 4'hF
      |-> ##[16:20] $changed(sck_o);
  endproperty
  a_start: assert property (p_start)
    else $error("data write did not start the serial clock");
  property p_txdone_w1c;
    reg_wr && reg_addr == 3'h3 && reg_wdata[6] && cb_ff[7] && idle_ff == 4'hF
      ##2 reg_rd && reg_addr == 3'h3 |=> !reg_rdata[6];
  endproperty
  a_txdone_w1c: assert property (p_txdone_w1c)
    else $error("transfer done flag survived a one write");
endmodule // sifd_core_chk

bind sifd_core sifd_core_chk chk_u (
  .clock(clock),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .irq(irq),
  .sck_o(sck_o),
  .sck_oe(sck_oe),
  .ss_n_i(ss_n_i)
);

// file: verif/sifd_link_peer.sv
// Far end of the link: a slave answering the controller, or a master clocking it
`timescale 1ns/100ps
module sifd_link_peer (
  input wire sck_o,
  input wire sck_oe,
  input wire mosi_o,
  input wire mosi_oe,
  input wire miso_o,
  input wire miso_oe,
  output wire sck_i,
  output wire mosi_i,
  output wire miso_i,
  output reg ss_n_i
);
  reg m_sck = 1'b0;
  reg m_mosi = 1'b1;
  reg s_miso = 1'b1;
  reg [7:0] tx_sh = 8'h00;
  reg [7:0] rx_sh = 8'h00;
  integer i;
  initial ss_n_i = 1'b1;
  // Wire level follows whichever party enables its driver
  assign sck_i = sck_oe ? sck_o : m_sck;
  assign mosi_i = mosi_oe ? mosi_o : m_mosi;
  assign miso_i = miso_oe ? miso_o : s_miso;
  always @(posedge sck_o) rx_sh <= {rx_sh[6:0], mosi_i};
  // Refill with inverted bits, so the next byte is the complement
  always @(negedge sck_o) begin
    tx_sh <= {tx_sh[6:0], ~tx_sh[7]};
    s_miso <= tx_sh[6];
  end
  task load(input [7:0] b);
    begin
      tx_sh = b;
      s_miso = b[7];
    end
  endtask
  task set_ss(input v);
    ss_n_i = v;
  endtask
  // Clock stands still outside the frame
  task master_xfer(input [7:0] b, input integer half, output [7:0] got);
    begin
      #1;
      ss_n_i = 1'b0;
      #half;
      for (i = 7; i >= 0; i = i - 1) begin
        m_mosi = b[i];
        #half;
        m_sck = 1'b1;
        got[i] = miso_i;
        #half;
        m_sck = 1'b0;
      end
      #half;
      ss_n_i = 1'b1;
      m_mosi = ~m_mosi;
    end
  endtask
endmodule // sifd_link_peer

// file: verif/sifd_core_tb_top.sv
// Self-checking bench for the controller's flags, enables and data path
`timescale 1ns/100ps
module sifd_core_tb_top;
  reg clock;
  reg rst;
  reg [2:0] reg_addr;
  reg [7:0] reg_wdata;
  reg reg_wr;
  reg reg_rd;
  reg irq_ack;
  wire [7:0] reg_rdata;
  wire irq, sck_i, sck_o, sck_oe, mosi_i, mosi_o, mosi_oe, miso_i, miso_o, miso_oe, ss_n_i;
  integer err_total = 0;
  integer tests_run = 0;
  integer cyc = 0;
  integer j;
  reg [7:0] v, b, r, got;
  sifd_core dut_u (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_ack(irq_ack), .irq(irq),
    .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_i), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(miso_i), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_n_i));
  sifd_link_peer peer_u (.sck_o(sck_o), .sck_oe(sck_oe), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_o(miso_o), .miso_oe(miso_oe), .sck_i(sck_i), .mosi_i(mosi_i), .miso_i(miso_i),
    .ss_n_i(ss_n_i));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // ----------------------------------------
  // Bus and checking tasks
  // ----------------------------------------
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("Error %s: expected %h, seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [2:0] a, output [7:0] d);
    begin
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
    end
  endtask
  task rdc(input string nm, input [2:0] a, input [7:0] exp);
    begin
      rd(a, v);
      chk(nm, v, exp);
    end
  endtask
  // Flag reads double as the completion handshake
  task poll(input [7:0] m);
    integer k;
    begin
      k = 0;
      rd(3'h3, v);
      while ((v & m) == 8'h00 && k < 400) begin
        rd(3'h3, v);
        k = k + 1;
      end
    end
  endtask
  task done(input string nm);
    $display("Test %s finished, %0d mismatches so far", nm, err_total);
  endtask
  task complete_run;
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    while (cyc < 20000) begin
      @(posedge clock);
      cyc = cyc + 1;
    end
    err_total = err_total + 1;
    complete_run;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst <= 1'b1;
    reg_addr <= 3'h0;
    reg_wdata <= 8'h00;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    irq_ack <= 1'b0;
    j = $urandom(32'h675a);
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    for (j = 0; j < 8; j = j + 1) rdc("reset value", j[2:0], 8'h00);
    wr(3'h2, 8'hF1);
    rdc("enables plain", 3'h2, 8'h01);
    done("reset");
    // DIV64 doubled: 160 ns link clock, slow enough for the pin synchronisers
    wr(3'h0, 8'h35);
    for (j = 0; j < 3; j = j + 1) begin
      {b, r} = 16'($urandom);
      peer_u.load(r);
      wr(3'h4, b);
      if (j == 2) wr(3'h4, ~b);
      poll(8'h80);
      chk("flags after byte", v, (j == 2) ? 8'hC0 : 8'h80);
      chk("irq legacy", {7'h00, irq}, 8'h01);
      chk("sent byte", peer_u.rx_sh, b);
      if (j == 1) begin
        @(posedge clock);
        irq_ack <= 1'b1;
        @(posedge clock);
        irq_ack <= 1'b0;
        rdc("flags after ack", 3'h3, 8'h00);
      end
      rdc("received byte", 3'h4, r);
      rdc("flags after data", 3'h3, 8'h00);
      // Let the trailing half period finish before the next byte
      repeat (24) @(posedge clock);
    end
    peer_u.set_ss(1'b0);
    poll(8'h80);
    chk("fault flag", v, 8'h80);
    rdc("master cleared", 3'h0, 8'h15);
    rd(3'h4, v);
    rdc("fault flag cleared", 3'h3, 8'h00);
    peer_u.set_ss(1'b1);
    done("plain master");
    wr(3'h0, 8'h01);
    {b, r} = 16'($urandom);
    wr(3'h4, b);
    peer_u.master_xfer(r, 80, got);
    chk("slave sent", got, b);
    poll(8'h80);
    rdc("slave received", 3'h4, r);
    done("plain slave");
    wr(3'h1, 8'h80);
    wr(3'h2, 8'hF0);
    rdc("enables buffered", 3'h2, 8'hF0);
    rdc("empty buffer", 3'h3, 8'h20);
    wr(3'h0, 8'h35);
    {b, r} = 16'($urandom);
    peer_u.load(r);
    wr(3'h4, ~b);
    wr(3'h4, b);
    rdc("buffer held", 3'h3, 8'h00);
    poll(8'h40);
    chk("both done", v, 8'hE0);
    chk("irq buffered", {7'h00, irq}, 8'h01);
    chk("last sent", peer_u.rx_sh, b);
    rdc("first entry", 3'h4, r);
    rdc("second entry", 3'h4, ~r);
    rdc("rx drained", 3'h3, 8'h60);
    wr(3'h3, 8'h00);
    rdc("zero write", 3'h3, 8'h60);
    wr(3'h3, 8'h40);
    rdc("done cleared", 3'h3, 8'h20);
    for (j = 0; j < 4; j = j + 1) begin
      wr(3'h4, 8'($urandom));
      poll(8'h20);
    end
    poll(8'h40);
    chk("overrun", v & 8'h81, 8'h81);
    rdc("kept entry", 3'h4, r);
    rdc("after pop", 3'h3, 8'hE0);
    // Buffer full again with nothing queued: overrun waits for a start
    for (j = 0; j < 2; j = j + 1) begin
      wr(3'h3, 8'h40);
      wr(3'h4, 8'($urandom));
      poll(8'h40);
    end
    chk("overrun deferred", v & 8'h01, 8'h00);
    wr(3'h3, 8'h40);
    wr(3'h4, 8'($urandom));
    rd(3'h3, v);
    chk("overrun at start", v & 8'h01, 8'h01);
    poll(8'h40);
    rd(3'h4, v);
    done("buffered");
    peer_u.set_ss(1'b0);
    poll(8'h10);
    chk("select trigger", v & 8'h10, 8'h10);
    rdc("master dropped", 3'h0, 8'h15);
    peer_u.set_ss(1'b1);
    wr(3'h3, 8'h10);
    rd(3'h3, v);
    chk("trigger cleared", v & 8'h10, 8'h00);
    wr(3'h1, 8'h84);
    wr(3'h0, 8'h35);
    peer_u.set_ss(1'b0);
    // Covers the three-stage select synchroniser with the fault path disabled by the select-disable bit
    repeat (12) @(posedge clock);
    rdc("master kept", 3'h0, 8'h35);
    rd(3'h3, v);
    chk("no trigger", v & 8'h10, 8'h00);
    peer_u.set_ss(1'b1);
    done("select line");
    complete_run;
  end
endmodule // sifd_core_tb_top
